/* File: shared/tscr_pkg.sv */
// tscr_pkg: constants and state types for the tile status and configuration bank.
// assumes a single core clock domain; every user writes tscr_pkg::name.
package tscr_pkg;

  // ****************************************************************
  // register numbers on the status read / write port
  // ****************************************************************
  localparam logic [7:0] ADDR_BOOT_STATUS = 8'h03; // boot status, read only
  localparam logic [7:0] ADDR_SECURITY = 8'h05; // security configuration
  localparam logic [7:0] ADDR_OSC_CTRL = 8'h06; // ring oscillator control
  localparam logic [7:0] ADDR_OSC_CNT0 = 8'h07; // first of four oscillator counts
  localparam logic [7:0] ADDR_OSC_CNT3 = 8'h0A; // last oscillator count
  localparam logic [7:0] ADDR_MEM_SIZE = 8'h0C; // ram size in bytes
  localparam logic [7:0] ADDR_DBG_SSR = 8'h10; // saved status word snapshot
  localparam logic [7:0] ADDR_DBG_SPC = 8'h11; // saved program counter snapshot
  localparam logic [7:0] ADDR_DBG_SSP = 8'h12; // saved stack pointer snapshot
  localparam logic [7:0] ADDR_CORE_SEL = 8'h13; // get-register core operand
  localparam logic [7:0] ADDR_REG_SEL = 8'h14; // get-register register operand

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int BS_OVR_BOOT = 8; // boot mode overridden by security word
  localparam int SEC_WR_LOCK = 31; // write lock of security register
  localparam int SEC_DBG_BLOCK = 14; // global debug disable
  localparam int SEC_OTP_LOCK_ALL = 12; // lock every otp sector
  localparam int SEC_SECT_LSB = 8; // per-sector lock bits 11:8
  localparam int SEC_OTP_REDUND = 7; // otp redundancy enable
  localparam int SEC_OTP_BOOT = 5; // boot image from otp
  localparam int SEC_JTAG_CFG = 4; // jtag blocked from pll/boot config
  localparam int SEC_TAP_BLOCK = 0; // jtag debug tap disabled
  localparam int OSC_CORE_EN = 1; // core ring oscillators enable
  localparam int OSC_PERIPH_EN = 0; // peripheral ring oscillators enable

  // ****************************************************************
  // masks and reset values
  // ****************************************************************
  localparam logic [31:0] SEC_WR_MASK = 32'h80005FB1; // writable security bits
  localparam logic [31:0] SEC_RESET = 32'h00000000; // before the otp copy lands
  localparam logic [1:0] OSC_CTRL_RESET = 2'h0; // both oscillator groups stopped
  localparam logic [31:0] SSR_WR_MASK = 32'h000006DF; // software-writable status bits
  localparam logic [31:0] SSR_CAP_MASK = 32'h000007DF; // bits captured on debug entry
  localparam logic [7:0] CORE_SEL_RESET = 8'h00; // core operand reset
  localparam logic [4:0] REG_SEL_RESET = 5'h00; // register operand reset
  localparam logic [31:0] MEM_SIZE_BYTES = 32'h00040000; // ram size, bits 1:0 zero
  localparam int NUM_OSC = 4; // number of ring oscillators

  // ****************************************************************
  // state of the bank, all reset flip-flops
  // ****************************************************************
  typedef struct packed {
    logic [13:0] strap_s1; // strap synchroniser, first stage
    logic [13:0] strap_s2; // strap synchroniser, second stage
    logic [3:0] osc_s1; // oscillator synchroniser, first stage
    logic [3:0] osc_s2; // oscillator synchroniser, second stage
    logic [3:0] osc_s3; // delayed copy for edge detection
    logic [31:0] boot; // assembled boot status word
    logic [31:0] sec; // security configuration
    logic [1:0] osc_ctrl; // oscillator enables
    logic [31:0] saved_status_word; // saved status word snapshot
    logic [31:0] saved_program_counter; // saved program counter snapshot
    logic [31:0] saved_stack_pointer; // saved stack pointer snapshot
    logic [7:0] core_sel; // get-register core operand
    logic [4:0] reg_sel; // get-register register operand
    logic [31:0] rdata; // read answer
    logic ack; // access answered
    logic err; // access refused or unmapped
  } tscr_state_t;

endpackage

/* File: core/tscr_regs.sv */
// tscr_regs: processor status register bank of a tile (boot, security, ring
// oscillators, ram size, debug snapshot and get-register operands).
// assumes one core clock; straps and oscillator outputs are asynchronous pins.
`timescale 1ns/1ps

// Operation
// R1 - read-only boot status, processor number 23:16
// R2 - boot bit 3: boot from ram
// R3 - boot bit 2: boot over jtag
// R4 - boot bits 1:0: sampled pll mode pins
// R5 - boot bit 4: skip otp level polling
// R6 - boot bit 5: second core powered off
// R7 - security bit 31 locks further writes
// R8 - security bit 14 blocks global debug
// R9 - bit 12 locks all, 11:8 sectors, 7 redundancy
// R10 - security bit 5 forces boot from otp
// R11 - security bit 4 blocks jtag config access
// R12 - security bit 0 disables jtag debug tap
// R13 - security register holds otp security copy
// R14 - four oscillator counters, software start/stop
// R15 - control bit 1 core, bit 0 peripheral
// R16 - software reads counts after ten stopped cycles
// R17 - count in bits 15:0, not reset
// R18 - counts 0x07..0x0A: tile cell, wire, periph
// R19 - oscillators asynchronous to tile clock
// R20 - ram size in bits 31:2, read only
// R21 - debug entry captures status, pc, sp
// R22 - debugger loads core and register operands
// R23 - reached only via status read/write port
// R24 - reserved reads zero, read-only writes ignored
// R25 - stopped oscillator freezes its counter
module tscr_regs (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // status read / write port from the core
  input wire logic i_ps_rd,
  input wire logic i_ps_wr,
  input wire logic [7:0] i_ps_addr,
  input wire logic [31:0] i_ps_wdata,
  input wire logic i_dbg_mode,
  output logic [31:0] o_ps_rdata,
  output logic o_ps_ack,
  output logic o_ps_err,
  // boot straps, asynchronous
  input wire logic [7:0] i_proc_num,
  input wire logic i_second_core_off,
  input wire logic i_skip_otp_poll,
  input wire logic i_boot_from_ram,
  input wire logic i_boot_from_jtag,
  input wire logic [1:0] i_pll_mode_pins,
  // security word copied from otp
  input wire logic i_otp_sec_load,
  input wire logic [31:0] i_otp_sec_word,
  // ring oscillator outputs, asynchronous
  input wire logic [3:0] i_ring_osc,
  // debugger entry snapshot
  input wire logic i_dbg_entry,
  input wire logic [31:0] i_saved_status_word,
  input wire logic [31:0] i_saved_program_counter,
  input wire logic [31:0] i_saved_stack_pointer,
  // security controls to the rest of the tile
  output logic o_dbg_global_block,
  output logic o_otp_lock_all,
  output logic [3:0] o_otp_sector_lock,
  output logic o_otp_redundancy,
  output logic o_boot_from_otp,
  output logic o_jtag_cfg_block,
  output logic o_jtag_tap_block,
  // get-register operands to the debug logic
  output logic [7:0] o_getreg_core,
  output logic [4:0] o_getreg_reg
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_s1_reg; // reset synchroniser, first stage
  logic rst_n; // released reset used by the bank except the oscillator counters

  // reset asserts at once, releases after two clock edges
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  // register number belongs to this bank
  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == tscr_pkg::ADDR_BOOT_STATUS) || (a == tscr_pkg::ADDR_SECURITY) ||
                (a == tscr_pkg::ADDR_OSC_CTRL) ||
                ((a >= tscr_pkg::ADDR_OSC_CNT0) && (a <= tscr_pkg::ADDR_OSC_CNT3)) ||
                (a == tscr_pkg::ADDR_MEM_SIZE) ||
                ((a >= tscr_pkg::ADDR_DBG_SSR) && (a <= tscr_pkg::ADDR_REG_SEL));
  endfunction

  // register is debug-writable (only while in debug mode)
  function automatic logic is_dbg_reg(input logic [7:0] a);
    is_dbg_reg = (a >= tscr_pkg::ADDR_DBG_SSR) && (a <= tscr_pkg::ADDR_REG_SEL);
  endfunction

  // ****************************************************************
  // state and oscillator counters
  // ****************************************************************
  tscr_pkg::tscr_state_t st_reg; // registered state
  tscr_pkg::tscr_state_t st_next; // next state
  // oscillator counts: power-up value zero, never touched by the system reset
  logic [15:0] cnt_reg [tscr_pkg::NUM_OSC] = '{default: 16'h0000}; // R17
  logic [3:0] osc_en; // per-oscillator enable
  logic wr_sec; // security write is taken
  logic [31:0] rd_word; // read multiplexer output

  // tile cell and wire follow the core enable, peripheral pair the other
  assign osc_en = {{2{st_reg.osc_ctrl[tscr_pkg::OSC_PERIPH_EN]}},
                   {2{st_reg.osc_ctrl[tscr_pkg::OSC_CORE_EN]}}}; // R15

  // counters advance on a synchronised rising edge of their oscillator
  for (genvar g = 0; g < tscr_pkg::NUM_OSC; g++) begin : g_osc
    // no reset term: the count survives a system reset
    always_ff @(posedge i_clk) begin // R17
      if (st_reg.osc_s2[g] && !st_reg.osc_s3[g] && osc_en[g]) begin // R14 R25
        cnt_reg[g] <= cnt_reg[g] + 16'h0001;
      end
    end
  end

  // read multiplexer, reserved bits forced to zero
  always_comb begin
    rd_word = 32'h00000000;
    case (i_ps_addr)
      tscr_pkg::ADDR_BOOT_STATUS: rd_word = st_reg.boot; // R1
      tscr_pkg::ADDR_SECURITY: rd_word = st_reg.sec & tscr_pkg::SEC_WR_MASK; // R24
      tscr_pkg::ADDR_OSC_CTRL: rd_word = {30'h00000000, st_reg.osc_ctrl};
      8'h07: rd_word = {16'h0000, cnt_reg[0]}; // R18
      8'h08: rd_word = {16'h0000, cnt_reg[1]}; // R18
      8'h09: rd_word = {16'h0000, cnt_reg[2]}; // R18
      8'h0A: rd_word = {16'h0000, cnt_reg[3]}; // R18
      tscr_pkg::ADDR_MEM_SIZE: rd_word = tscr_pkg::MEM_SIZE_BYTES & 32'hFFFFFFFC; // R20
      tscr_pkg::ADDR_DBG_SSR: rd_word = st_reg.saved_status_word;
      tscr_pkg::ADDR_DBG_SPC: rd_word = st_reg.saved_program_counter;
      tscr_pkg::ADDR_DBG_SSP: rd_word = st_reg.saved_stack_pointer;
      tscr_pkg::ADDR_CORE_SEL: rd_word = {24'h000000, st_reg.core_sel};
      tscr_pkg::ADDR_REG_SEL: rd_word = {27'h0000000, st_reg.reg_sel};
      default: rd_word = 32'h00000000; // unmapped reads zero
    endcase
  end

  // security write is taken only while the lock bit is clear
  assign wr_sec = i_ps_wr && (i_ps_addr == tscr_pkg::ADDR_SECURITY) &&
                  !st_reg.sec[tscr_pkg::SEC_WR_LOCK]; // R7

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb begin
    st_next = st_reg;
    // synchronisers: first stage read only by the second
    st_next.strap_s1 = {i_proc_num, i_second_core_off, i_skip_otp_poll, i_boot_from_ram,
                        i_boot_from_jtag, i_pll_mode_pins};
    st_next.strap_s2 = st_reg.strap_s1;
    st_next.osc_s1 = i_ring_osc; // R19
    st_next.osc_s2 = st_reg.osc_s1;
    st_next.osc_s3 = st_reg.osc_s2;
    // boot status rebuilt each cycle from sampled straps
    st_next.boot = {8'h00, st_reg.strap_s2[13:6], 7'h00,
                    st_reg.sec[tscr_pkg::SEC_OTP_BOOT], 2'h0,
                    st_reg.strap_s2[5:0]}; // R1 R2 R3 R4 R5 R6
    // answer defaults
    st_next.ack = i_ps_rd || i_ps_wr; // R23
    st_next.err = 1'b0;
    st_next.rdata = i_ps_rd ? rd_word : 32'h00000000;
    // refused writes: unmapped, read-only, locked or debug-only
    if (i_ps_wr) begin
      if (!is_mapped(i_ps_addr)) begin
        st_next.err = 1'b1;
      end else if ((i_ps_addr == tscr_pkg::ADDR_BOOT_STATUS) ||
                   (i_ps_addr == tscr_pkg::ADDR_MEM_SIZE) ||
                   ((i_ps_addr >= tscr_pkg::ADDR_OSC_CNT0) &&
                    (i_ps_addr <= tscr_pkg::ADDR_OSC_CNT3))) begin
        st_next.err = 1'b1; // R24
      end else if ((i_ps_addr == tscr_pkg::ADDR_SECURITY) && !wr_sec) begin
        st_next.err = 1'b1; // R7
      end else if (is_dbg_reg(i_ps_addr) && !i_dbg_mode) begin
        st_next.err = 1'b1;
      end
    end
    if (i_ps_rd && !is_mapped(i_ps_addr)) begin
      st_next.err = 1'b1;
    end
    // security word: the otp copy wins over a software write
    if (i_otp_sec_load) begin
      st_next.sec = i_otp_sec_word & tscr_pkg::SEC_WR_MASK; // R13
    end else if (wr_sec) begin
      st_next.sec = i_ps_wdata & tscr_pkg::SEC_WR_MASK; // R7 R24
    end
    // oscillator control
    if (i_ps_wr && (i_ps_addr == tscr_pkg::ADDR_OSC_CTRL)) begin
      st_next.osc_ctrl = i_ps_wdata[1:0]; // R15
    end
    // debug registers written in debug mode
    if (i_ps_wr && i_dbg_mode) begin
      case (i_ps_addr)
        tscr_pkg::ADDR_DBG_SSR: begin
          st_next.saved_status_word = (st_reg.saved_status_word & ~tscr_pkg::SSR_WR_MASK) |
                        (i_ps_wdata & tscr_pkg::SSR_WR_MASK); // R24
        end
        tscr_pkg::ADDR_DBG_SPC: st_next.saved_program_counter = i_ps_wdata;
        tscr_pkg::ADDR_DBG_SSP: st_next.saved_stack_pointer = i_ps_wdata;
        tscr_pkg::ADDR_CORE_SEL: st_next.core_sel = i_ps_wdata[7:0]; // R22
        tscr_pkg::ADDR_REG_SEL: st_next.reg_sel = i_ps_wdata[4:0]; // R22
        default: st_next.core_sel = st_reg.core_sel; // nothing else debug-writable
      endcase
    end
    // debugger entry snapshot wins over a software write
    if (i_dbg_entry) begin
      st_next.saved_status_word = i_saved_status_word & tscr_pkg::SSR_CAP_MASK; // R21
      st_next.saved_program_counter = i_saved_program_counter; // R21
      st_next.saved_stack_pointer = i_saved_stack_pointer; // R21
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.sec <= tscr_pkg::SEC_RESET;
      st_reg.osc_ctrl <= tscr_pkg::OSC_CTRL_RESET; // R15
      st_reg.core_sel <= tscr_pkg::CORE_SEL_RESET;
      st_reg.reg_sel <= tscr_pkg::REG_SEL_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // outputs, each straight from a flip-flop
  // ****************************************************************
  assign o_ps_rdata = st_reg.rdata;
  assign o_ps_ack = st_reg.ack;
  assign o_ps_err = st_reg.err;
  assign o_dbg_global_block = st_reg.sec[tscr_pkg::SEC_DBG_BLOCK]; // R8
  assign o_otp_lock_all = st_reg.sec[tscr_pkg::SEC_OTP_LOCK_ALL]; // R9
  assign o_otp_sector_lock = st_reg.sec[tscr_pkg::SEC_SECT_LSB +: 4]; // R9
  assign o_otp_redundancy = st_reg.sec[tscr_pkg::SEC_OTP_REDUND]; // R9
  assign o_boot_from_otp = st_reg.sec[tscr_pkg::SEC_OTP_BOOT]; // R10
  assign o_jtag_cfg_block = st_reg.sec[tscr_pkg::SEC_JTAG_CFG]; // R11
  assign o_jtag_tap_block = st_reg.sec[tscr_pkg::SEC_TAP_BLOCK]; // R12
  assign o_getreg_core = st_reg.core_sel; // R22
  assign o_getreg_reg = st_reg.reg_sel; // R22

  // ****************************************************************
  // assertions
  // ****************************************************************
  // a locked security write with no otp load
  sequence s_locked_sec_wr;
    i_ps_wr && (i_ps_addr == tscr_pkg::ADDR_SECURITY) &&
    st_reg.sec[tscr_pkg::SEC_WR_LOCK] && !i_otp_sec_load;
  endsequence

  // core oscillators held stopped for two cycles
  sequence s_core_stopped;
    !st_reg.osc_ctrl[tscr_pkg::OSC_CORE_EN] [*2];
  endsequence

  AST_BOOT_RO: assert property (@(posedge i_clk) disable iff (!rst_n) // R1
    i_ps_wr && (i_ps_addr == tscr_pkg::ADDR_BOOT_STATUS) |=> o_ps_err && o_ps_ack)
    else $error("boot status write not refused");

  AST_BOOT_FIELDS: assert property (@(posedge i_clk) disable iff (!rst_n) // R4
    ##2 st_reg.boot[23:16] == $past(st_reg.strap_s1[13:6], 2) &&
    st_reg.boot[5:0] == $past(st_reg.strap_s1[5:0], 2) &&
    st_reg.boot[31:24] == 8'h00 && st_reg.boot[15:9] == 7'h00)
    else $error("boot status does not follow straps");

  AST_SEC_LOCK: assert property (@(posedge i_clk) disable iff (!rst_n) // R7
    s_locked_sec_wr |=> $stable(st_reg.sec) && o_ps_err)
    else $error("locked security register changed");

  AST_SEC_DBG_OUT: assert property (@(posedge i_clk) disable iff (!rst_n) // R8
    wr_sec && !i_otp_sec_load |=> o_dbg_global_block == $past(i_ps_wdata[14]) &&
    o_jtag_tap_block == $past(i_ps_wdata[0]))
    else $error("security controls do not follow write");

  AST_OSC_FREEZE: assert property (@(posedge i_clk) disable iff (!rst_n) // R25
    s_core_stopped |-> $stable(cnt_reg[0]) && $stable(cnt_reg[1]))
    else $error("stopped oscillator counter moved");

  AST_RD_ACK: assert property (@(posedge i_clk) disable iff (!rst_n) // R23
    i_ps_rd |=> o_ps_ack ##1 !o_ps_ack || $past(i_ps_rd) || $past(i_ps_wr))
    else $error("read not answered in one cycle");

  AST_CNT_RSVD: assert property (@(posedge i_clk) disable iff (!rst_n) // R17
    i_ps_rd && (i_ps_addr >= tscr_pkg::ADDR_OSC_CNT0) &&
    (i_ps_addr <= tscr_pkg::ADDR_OSC_CNT3) |=> o_ps_rdata[31:16] == 16'h0000)
    else $error("counter reserved bits not zero");

  AST_MEM_SIZE: assert property (@(posedge i_clk) disable iff (!rst_n) // R20
    i_ps_rd && (i_ps_addr == tscr_pkg::ADDR_MEM_SIZE) |=>
    o_ps_rdata == (tscr_pkg::MEM_SIZE_BYTES & 32'hFFFFFFFC) && !o_ps_err)
    else $error("ram size read wrong");

  AST_DBG_CAPTURE: assert property (@(posedge i_clk) disable iff (!rst_n) // R21
    i_dbg_entry |=> st_reg.saved_status_word == ($past(i_saved_status_word) & tscr_pkg::SSR_CAP_MASK) &&
    st_reg.saved_program_counter == $past(i_saved_program_counter) &&
    st_reg.saved_stack_pointer == $past(i_saved_stack_pointer))
    else $error("debug entry snapshot wrong");

endmodule // tscr_regs

/* File: dv/tscr_osc_model.sv */
// tscr_osc_model: four free-running ring oscillators at the far side of the bank.
// assumes a 10 ns core clock; every level lasts well over two core clocks.
`timescale 1ns/1ps
module tscr_osc_model (
  // oscillator levels
  output logic [3:0] o_ring_osc
);
  // ****************************************************************
  // free-running toggles, periods unrelated to the core clock
  // ****************************************************************
  initial begin
    o_ring_osc = 4'h0;
  end
  always #23.1 o_ring_osc[0] = ~o_ring_osc[0];
  always #27.7 o_ring_osc[1] = ~o_ring_osc[1];
  always #31.3 o_ring_osc[2] = ~o_ring_osc[2];
  always #37.9 o_ring_osc[3] = ~o_ring_osc[3];
endmodule // tscr_osc_model

/* File: dv/test_tile_status_config_regs.sv */
// test_tile_status_config_regs: self-checking bench of the status register bank.
// assumes the oscillator model and the bank; the bench plays the core's port.
`timescale 1ns/1ps
module test_tile_status_config_regs;
  // ****************************************************************
  // signals
  // ****************************************************************
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_ps_rd = 1'b0, i_ps_wr = 1'b0, i_dbg_mode = 1'b0;
  logic [7:0] i_ps_addr = 8'h00;
  logic [31:0] i_ps_wdata = 32'h0, ss = 32'h0, pc = 32'h0, sp = 32'h0;
  logic [13:0] straps = 14'h0; // proc number, core off, skip, ram, jtag, pll pins
  logic i_otp_sec_load = 1'b0, i_dbg_entry = 1'b0;
  logic [31:0] i_otp_sec_word = 32'h0, o_ps_rdata, rd_data, seed = 32'h6995E27E, w;
  logic o_ps_ack, o_ps_err, rd_err, dgb, ola, ord, obo, ojc, ojt;
  logic [3:0] i_ring_osc, osl;
  logic [7:0] o_getreg_core;
  logic [4:0] o_getreg_reg;
  logic [31:0] cnt_a [4], cnt_b [4];
  int err_count = 0, total_checks = 0, cyc = 0;
  always #5 i_clk = ~i_clk; // 100 MHz
  // ****************************************************************
  // design and oscillator partner
  // ****************************************************************
  tscr_osc_model osc (.o_ring_osc(i_ring_osc));
  tscr_regs DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_ps_rd(i_ps_rd), .i_ps_wr(i_ps_wr),
    .i_ps_addr(i_ps_addr), .i_ps_wdata(i_ps_wdata), .i_dbg_mode(i_dbg_mode),
    .o_ps_rdata(o_ps_rdata), .o_ps_ack(o_ps_ack), .o_ps_err(o_ps_err),
    .i_proc_num(straps[13:6]), .i_second_core_off(straps[5]), .i_skip_otp_poll(straps[4]),
    .i_boot_from_ram(straps[3]), .i_boot_from_jtag(straps[2]), .i_pll_mode_pins(straps[1:0]),
    .i_otp_sec_load(i_otp_sec_load), .i_otp_sec_word(i_otp_sec_word), .i_ring_osc(i_ring_osc),
    .i_dbg_entry(i_dbg_entry), .i_saved_status_word(ss), .i_saved_program_counter(pc),
    .i_saved_stack_pointer(sp), .o_dbg_global_block(dgb), .o_otp_lock_all(ola),
    .o_otp_sector_lock(osl), .o_otp_redundancy(ord), .o_boot_from_otp(obo),
    .o_jtag_cfg_block(ojc), .o_jtag_tap_block(ojt), .o_getreg_core(o_getreg_core),
    .o_getreg_reg(o_getreg_reg));
  // ****************************************************************
  // helpers
  // ****************************************************************
  // next random word, shift register with feedback taps
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected boot status word from straps and the boot override bit
  function automatic logic [31:0] boot_exp(input logic [13:0] s, input logic ovr);
    return {8'h00, s[13:6], 7'h00, ovr, 2'h0, s[5:0]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one access on the status port; answer sampled in the ack cycle
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk); #1;
    i_ps_rd = !wr; i_ps_wr = wr; i_ps_addr = a; i_ps_wdata = d;
    @(posedge i_clk); #1;
    i_ps_rd = 1'b0; i_ps_wr = 1'b0; rd_data = o_ps_rdata; rd_err = o_ps_err;
    chk({31'h0, o_ps_ack}, 32'h1);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
    acc(1'b0, a, 32'h0);
    chk(rd_data, exp);
    chk({31'h0, rd_err}, {31'h0, eerr});
  endtask
  task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic eerr);
    acc(1'b1, a, d);
    chk({31'h0, rd_err}, {31'h0, eerr});
  endtask
  task automatic read_counts(output logic [31:0] c [4]);
    for (int k = 0; k < 4; k++) begin
      acc(1'b0, tscr_pkg::ADDR_OSC_CNT0 + 8'(k), 32'h0);
      c[k] = rd_data;
      chk(c[k] & 32'hFFFF0000, 32'h0);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ****************************************************************
  // watchdog on the whole run
  // ****************************************************************
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    seed = lfsr(seed);
    straps = seed[13:0];
    repeat (20) @(posedge i_clk);
    #1 i_rst_n = 1'b1;
    repeat (8) @(posedge i_clk);
    // reset values and read-only words
    rd_chk(tscr_pkg::ADDR_OSC_CTRL, 32'h0, 1'b0);
    rd_chk(tscr_pkg::ADDR_SECURITY, 32'h0, 1'b0);
    rd_chk(tscr_pkg::ADDR_BOOT_STATUS, boot_exp(straps, 1'b0), 1'b0);
    wr_chk(tscr_pkg::ADDR_BOOT_STATUS, 32'hFFFFFFFF, 1'b1);
    rd_chk(tscr_pkg::ADDR_BOOT_STATUS, boot_exp(straps, 1'b0), 1'b0);
    rd_chk(tscr_pkg::ADDR_MEM_SIZE, tscr_pkg::MEM_SIZE_BYTES, 1'b0);
    wr_chk(tscr_pkg::ADDR_MEM_SIZE, 32'h0, 1'b1);
    rd_chk(8'h04, 32'h0, 1'b1);
    rd_chk(8'h0B, 32'h0, 1'b1);
    rd_chk(8'h15, 32'h0, 1'b1);
    // debug snapshot and get-register operands
    seed = lfsr(seed);
    wr_chk(tscr_pkg::ADDR_DBG_SPC, seed, 1'b1);
    ss = lfsr(seed); pc = lfsr(ss); sp = lfsr(pc); seed = sp;
    @(posedge i_clk); #1 i_dbg_entry = 1'b1;
    @(posedge i_clk); #1 i_dbg_entry = 1'b0;
    rd_chk(tscr_pkg::ADDR_DBG_SSR, ss & tscr_pkg::SSR_CAP_MASK, 1'b0);
    rd_chk(tscr_pkg::ADDR_DBG_SPC, pc, 1'b0);
    rd_chk(tscr_pkg::ADDR_DBG_SSP, sp, 1'b0);
    i_dbg_mode = 1'b1;
    seed = lfsr(seed);
    wr_chk(tscr_pkg::ADDR_CORE_SEL, seed, 1'b0);
    rd_chk(tscr_pkg::ADDR_CORE_SEL, seed & 32'hFF, 1'b0);
    chk({24'h0, o_getreg_core}, seed & 32'hFF);
    wr_chk(tscr_pkg::ADDR_REG_SEL, ~seed, 1'b0);
    rd_chk(tscr_pkg::ADDR_REG_SEL, ~seed & 32'h1F, 1'b0);
    chk({27'h0, o_getreg_reg}, ~seed & 32'h1F);
    wr_chk(tscr_pkg::ADDR_DBG_SSR, seed, 1'b0);
    w = (seed & tscr_pkg::SSR_WR_MASK) | (ss & tscr_pkg::SSR_CAP_MASK & ~tscr_pkg::SSR_WR_MASK);
    rd_chk(tscr_pkg::ADDR_DBG_SSR, w, 1'b0);
    // security word from otp, software writes, then the lock
    seed = lfsr(seed);
    w = seed & 32'h7FFFFFFF;
    @(posedge i_clk); #1 i_otp_sec_load = 1'b1; i_otp_sec_word = w;
    @(posedge i_clk); #1 i_otp_sec_load = 1'b0;
    rd_chk(tscr_pkg::ADDR_SECURITY, w & tscr_pkg::SEC_WR_MASK, 1'b0);
    chk({23'h0, dgb, ola, osl, ord, obo, ojc, ojt},
      {23'h0, w[14], w[12], w[11:8], w[7], w[5], w[4], w[0]});
    rd_chk(tscr_pkg::ADDR_BOOT_STATUS, boot_exp(straps, w[5]), 1'b0);
    seed = lfsr(seed);
    w = seed | 32'h80000000;
    wr_chk(tscr_pkg::ADDR_SECURITY, w, 1'b0);
    wr_chk(tscr_pkg::ADDR_SECURITY, ~w, 1'b1);
    rd_chk(tscr_pkg::ADDR_SECURITY, w & tscr_pkg::SEC_WR_MASK, 1'b0);
    // oscillator groups: each enable pattern, then a frozen value
    read_counts(cnt_a);
    for (int m = 3; m >= 1; m--) begin
      wr_chk(tscr_pkg::ADDR_OSC_CTRL, 32'(m), 1'b0);
      repeat (150) @(posedge i_clk);
      wr_chk(tscr_pkg::ADDR_OSC_CTRL, 32'h0, 1'b0);
      repeat (12) @(posedge i_clk);
      read_counts(cnt_b);
      for (int k = 0; k < 4; k++) begin
        chk({31'h0, cnt_b[k] !== cnt_a[k]}, {31'h0, (k < 2) ? m[1] : m[0]});
      end
      repeat (40) @(posedge i_clk);
      read_counts(cnt_a);
      for (int k = 0; k < 4; k++) chk(cnt_a[k], cnt_b[k]);
    end
    // a second reset keeps the counts and clears the controls
    @(posedge i_clk); #1 i_rst_n = 1'b0;
    repeat (3) @(posedge i_clk);
    #1 i_rst_n = 1'b1;
    repeat (5) @(posedge i_clk);
    read_counts(cnt_b);
    for (int k = 0; k < 4; k++) chk(cnt_b[k], cnt_a[k]);
    rd_chk(tscr_pkg::ADDR_OSC_CTRL, 32'h0, 1'b0);
    rd_chk(tscr_pkg::ADDR_SECURITY, 32'h0, 1'b0);
    print_verdict();
  end
endmodule // test_tile_status_config_regs
